// ---- pkg/owm_pkg.sv ----
// constants and types for the oscillator warm-up and operation-mode control block
// assumes a single system clock; oscillator ticks arrive as synchronous enables
package owm_pkg;

    // register byte addresses on the apb bus
    localparam logic [11:0] ADDR_SYS2 = 12'h000;
    localparam logic [11:0] ADDR_WUC = 12'h004;
    localparam logic [11:0] ADDR_WCMP = 12'h008;
    localparam logic [11:0] ADDR_TBC = 12'h00C;
    localparam logic [11:0] ADDR_IEN = 12'h010;
    localparam logic [11:0] ADDR_STAT = 12'h014;

    // system_control_two field positions
    localparam int B_XEN = 0;
    localparam int B_LOW_OSC_ENABLE = 1;
    localparam int B_MAIN_CLOCK_SELECT = 2;
    localparam int B_IDLE = 3;
    localparam int B_HALT = 4;

    // warmup_control_reg field positions
    localparam int B_WSEL = 0;
    localparam int B_WDIV = 1;
    localparam int B_WABORT = 3;

    // time_base_control and interrupt_enable_reg positions
    localparam int B_TBEN = 0;
    localparam int B_IMF = 0;
    localparam int B_EFTB = 1;

    // status register positions
    localparam int B_SMODE = 0;
    localparam int B_SLOW = 3;
    localparam int B_SBUSY = 4;
    localparam int B_SCNT = 8;

    // reset values
    localparam logic XEN_RST = 1'b1;
    localparam logic [1:0] WDIV_RST = 2'h3;
    localparam logic [7:0] WCMP_RST = 8'h66;

    // counter geometry
    localparam int CNT_W = 14;
    localparam int CMP_W = 8;
    localparam int PRE_W = 3;

    // cycles the main clock switch-over takes after the select bit changes
    localparam int SW_CYCLES_DEF = 4;

    typedef enum logic [2:0] {
        M_SINGLE_NORMAL,
        M_SINGLE_IDLE,
        M_HALT_TB_ONLY,
        M_DUAL_NORMAL,
        M_DUAL_IDLE,
        M_SLOW_HF_ON,
        M_SLOW_HF_OFF,
        M_LF_SLEEP
    } owm_mode_t;

endpackage

// ---- pkg/owm_wu_if.sv ----
// carrier between the mode controller and its warm-up counter
// assumes both ends run on the same system clock
`timescale 1ns/1ns
interface owm_wu_if;
    logic start;
    logic abort;
    logic sel;
    logic [1:0] div;
    logic [7:0] cmp;
    logic hf_tick;
    logic lf_tick;
    logic busy;
    logic done;
    logic [7:0] count_hi;

    modport ctrl (output start, abort, sel, div, cmp, hf_tick, lf_tick,
                  input busy, done, count_hi);
    modport cnt (input start, abort, sel, div, cmp, hf_tick, lf_tick,
                 output busy, done, count_hi);
endinterface

// ---- core/owm_warmup_counter.sv ----
// software-started warm-up counter: source pick, 3-stage divider, 14-stage counter
// assumes oscillator ticks are one-cycle enables synchronous to sys_clk
`timescale 1ns/1ns
module owm_warmup_counter #(
    parameter int CW = owm_pkg::CNT_W,
    parameter int MW = owm_pkg::CMP_W
) (
    // clock, reset, enable
    input logic sys_clk,
    input logic srst,
    input logic ce,
    // link to controller
    owm_wu_if.cnt wu
);
    import owm_pkg::*;

    typedef struct packed {
        logic busy;
        logic src;
        logic [PRE_W-1:0] pre;
        logic [CW-1:0] cnt;
        logic done;
    } owm_wu_st_t;

    owm_wu_st_t s_r, s_nxt;
    logic tick;
    logic [PRE_W:0] mask4;
    logic [PRE_W-1:0] mask;
    logic [CW-1:0] cnt_inc;

    ////////////////////////////////////////////////////////////////////////////
    // next state: abort beats start, start beats counting
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        tick = s_r.src ? wu.lf_tick : wu.hf_tick;
        mask4 = ((PRE_W+1)'(1) << wu.div) - (PRE_W+1)'(1);
        mask = mask4[PRE_W-1:0];
        cnt_inc = s_r.cnt + CW'(1);
        if (wu.abort) begin
            s_nxt.busy = 1'b0;
            s_nxt.cnt = '0;
            s_nxt.pre = '0;
        end else if (wu.start) begin
            s_nxt.busy = 1'b1;
            s_nxt.src = wu.sel;
            s_nxt.cnt = '0;
            s_nxt.pre = '0;
        end else if (s_r.busy && tick) begin
            if ((s_r.pre & mask) == mask) begin
                s_nxt.pre = '0;
                // compare on upper bits gives compare x 64 divided periods
                if (cnt_inc[CW-1:CW-MW] == wu.cmp) begin
                    s_nxt.done = 1'b1;
                    s_nxt.busy = 1'b0;
                    s_nxt.cnt = '0;
                end else begin
                    s_nxt.cnt = cnt_inc;
                end
            end else begin
                s_nxt.pre = s_r.pre + PRE_W'(1);
            end
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign wu.busy = s_r.busy;
    assign wu.done = s_r.done;
    assign wu.count_hi = s_r.cnt[CW-1:CW-MW];

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk iff ce);
    endclocking
    default disable iff (srst);

    property p_done_stops;
        wu.done |-> !wu.busy && wu.count_hi == '0 ##1 !wu.done;
    endproperty
    a_done_stops: assert property (p_done_stops) else $error("done did not stop counter");

    property p_abort_clears;
        wu.abort |=> !wu.busy && wu.count_hi == '0 && !wu.done;
    endproperty
    a_abort_clears: assert property (p_abort_clears) else $error("abort left counter running");
endmodule

// ---- core/owm_mode_ctrl.sv ----
// operation-mode and clock control with software warm-up, apb register slave
// assumes inputs synchronous to sys_clk; tb_src_clk is the time-base source level
`timescale 1ns/1ns
module owm_mode_ctrl #(
    parameter int SW_DELAY = owm_pkg::SW_CYCLES_DEF
) (
    // clock, reset, enable
    input logic sys_clk,
    input logic srst,
    input logic ce,
    // apb slave
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator ticks and wake sources
    input logic hf_tick,
    input logic lf_tick,
    input logic tb_src_clk,
    input logic int_wake,
    // clock gating and mode outputs
    output logic cpu_clk_en,
    output logic wdt_clk_en,
    output logic periph_clk_en,
    output logic main_clk_low,
    output logic prescaler_run,
    output logic xtal_pins_dedicated,
    output logic high_osc_run,
    output logic low_osc_run,
    output owm_pkg::owm_mode_t op_mode,
    // event pulses into the interrupt latches
    output logic warmup_done_interrupt,
    output logic time_base_interrupt,
    output logic resume_isr
);
    import owm_pkg::*;

    typedef struct packed {
        logic high_osc_enable;
        logic low_osc_enable;
        logic main_clock_select;
        logic idle;
        logic halt;
        logic wsel;
        logic [1:0] wdiv;
        logic wabort;
        logic [7:0] wcmp;
        logic tben;
        logic master_interrupt_enable;
        logic eftb;
        owm_mode_t mode;
        logic clk_low;
        logic [7:0] sw_cnt;
        logic tb_q;
        logic tb_armed;
        logic tbt_set;
        logic res_isr;
        logic [31:0] rdata;
    } owm_st_t;

    owm_st_t s_r, s_nxt;
    owm_wu_if wu ();

    logic acc, wr, setup;
    logic mapped;
    logic wr_sys2;
    logic tb_fall;
    logic [31:0] rd;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, so pready follows ce
    assign setup = psel && !penable;
    assign acc = psel && penable;
    assign wr = acc && pwrite && ce;
    assign mapped = paddr == ADDR_SYS2 || paddr == ADDR_WUC || paddr == ADDR_WCMP ||
                    paddr == ADDR_TBC || paddr == ADDR_IEN || paddr == ADDR_STAT;
    assign pready = acc && ce;
    assign pslverr = acc && ce && !mapped;
    assign wr_sys2 = wr && paddr == ADDR_SYS2 && mapped;
    assign tb_fall = s_r.tb_q && !tb_src_clk;

    // start only on a rising enable, so rewriting a 1 does nothing
    assign wu.start = wr_sys2 && ((pwdata[B_XEN] && !s_r.high_osc_enable) ||
                                  (pwdata[B_LOW_OSC_ENABLE] && !s_r.low_osc_enable));
    assign wu.abort = s_r.wabort;
    assign wu.sel = s_r.wsel;
    assign wu.div = s_r.wdiv;
    assign wu.cmp = s_r.wcmp;
    assign wu.hf_tick = hf_tick;
    assign wu.lf_tick = lf_tick;

    owm_warmup_counter u_wu (
        .sys_clk(sys_clk),
        .srst(srst),
        .ce(ce),
        .wu(wu)
    );

    // read mux, captured in the setup cycle so prdata is a flop
    always_comb begin
        rd = '0;
        unique case (paddr)
            ADDR_SYS2: begin
                rd[B_XEN] = s_r.high_osc_enable;
                rd[B_LOW_OSC_ENABLE] = s_r.low_osc_enable;
                rd[B_MAIN_CLOCK_SELECT] = s_r.main_clock_select;
                rd[B_IDLE] = s_r.idle;
                rd[B_HALT] = s_r.halt;
            end
            ADDR_WUC: begin
                rd[B_WSEL] = s_r.wsel;
                rd[B_WDIV +: 2] = s_r.wdiv;
                rd[B_WABORT] = s_r.wabort;
            end
            ADDR_WCMP: rd[7:0] = s_r.wcmp;
            ADDR_TBC: rd[B_TBEN] = s_r.tben;
            ADDR_IEN: begin
                rd[B_IMF] = s_r.master_interrupt_enable;
                rd[B_EFTB] = s_r.eftb;
            end
            ADDR_STAT: begin
                rd[B_SMODE +: 3] = s_r.mode;
                rd[B_SLOW] = s_r.clk_low;
                rd[B_SBUSY] = wu.busy;
                rd[B_SCNT +: 8] = wu.count_hi;
            end
            default: rd = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state: register writes, clock switch-over, mode machine
    always_comb begin
        s_nxt = s_r;
        s_nxt.tbt_set = 1'b0;
        s_nxt.res_isr = 1'b0;
        s_nxt.wabort = 1'b0; // abort lives one cycle, then reads 0
        s_nxt.tb_q = tb_src_clk;
        if (setup) begin
            s_nxt.rdata = rd;
        end

        // software writes; abort leaves the enables alone
        if (wr_sys2) begin
            s_nxt.high_osc_enable = pwdata[B_XEN];
            s_nxt.low_osc_enable = pwdata[B_LOW_OSC_ENABLE];
            s_nxt.main_clock_select = pwdata[B_MAIN_CLOCK_SELECT];
            s_nxt.idle = pwdata[B_IDLE];
            s_nxt.halt = pwdata[B_HALT];
        end
        if (wr && paddr == ADDR_WUC) begin
            s_nxt.wsel = pwdata[B_WSEL];
            s_nxt.wdiv = pwdata[B_WDIV +: 2];
            s_nxt.wabort = pwdata[B_WABORT];
        end
        if (wr && paddr == ADDR_WCMP) begin
            s_nxt.wcmp = pwdata[7:0];
        end
        if (wr && paddr == ADDR_TBC) begin
            s_nxt.tben = pwdata[B_TBEN];
        end
        if (wr && paddr == ADDR_IEN) begin
            s_nxt.master_interrupt_enable = pwdata[B_IMF];
            s_nxt.eftb = pwdata[B_EFTB];
        end

        // switch-over lags the select bit; low side needs the low oscillator and
        // the gear side the high one, so slow-off and sleep hold the low clock
        if (s_r.main_clock_select != s_r.clk_low && (s_r.main_clock_select ? s_r.low_osc_enable :
                !(s_r.mode inside {M_SLOW_HF_OFF, M_LF_SLEEP}))) begin
            if (s_r.sw_cnt == 8'(SW_DELAY - 1)) begin
                s_nxt.clk_low = s_r.main_clock_select;
                s_nxt.sw_cnt = '0;
            end else begin
                s_nxt.sw_cnt = s_r.sw_cnt + 8'h01;
            end
        end else begin
            s_nxt.sw_cnt = '0;
        end

        unique case (s_r.mode)
            M_SINGLE_NORMAL: begin
                if (s_r.halt) begin
                    s_nxt.mode = M_HALT_TB_ONLY;
                    s_nxt.tb_armed = s_r.tben;
                end else if (s_r.idle) begin
                    s_nxt.mode = M_SINGLE_IDLE;
                end else if (s_r.low_osc_enable && !wu.busy) begin
                    s_nxt.mode = M_DUAL_NORMAL;
                end
            end
            M_SINGLE_IDLE: begin
                if (int_wake) begin
                    s_nxt.mode = M_SINGLE_NORMAL;
                    s_nxt.idle = 1'b0;
                    s_nxt.res_isr = s_r.master_interrupt_enable;
                end
            end
            M_HALT_TB_ONLY: begin
                // exit regardless of the time-base enable bit
                if (tb_fall) begin
                    s_nxt.mode = M_SINGLE_NORMAL;
                    s_nxt.halt = 1'b0;
                    if (s_r.tb_armed) begin
                        s_nxt.tbt_set = 1'b1;
                        s_nxt.res_isr = s_r.master_interrupt_enable && s_r.eftb;
                    end
                end
            end
            M_DUAL_NORMAL: begin
                if (s_nxt.clk_low) begin
                    s_nxt.mode = M_SLOW_HF_ON;
                end else if (s_r.idle) begin
                    s_nxt.mode = M_DUAL_IDLE;
                end else if (!s_r.low_osc_enable) begin
                    s_nxt.mode = M_SINGLE_NORMAL;
                end
            end
            M_DUAL_IDLE: begin
                if (int_wake) begin
                    s_nxt.mode = M_DUAL_NORMAL;
                    s_nxt.idle = 1'b0;
                    s_nxt.res_isr = s_r.master_interrupt_enable;
                end
            end
            M_SLOW_HF_ON: begin
                if (!s_nxt.clk_low) begin
                    s_nxt.mode = M_DUAL_NORMAL;
                end else if (!s_r.high_osc_enable) begin
                    s_nxt.mode = M_SLOW_HF_OFF;
                end
            end
            M_SLOW_HF_OFF: begin
                if (s_r.high_osc_enable && !wu.busy) begin
                    s_nxt.mode = M_SLOW_HF_ON;
                end else if (s_r.idle) begin
                    s_nxt.mode = M_LF_SLEEP;
                end
            end
            M_LF_SLEEP: begin
                if (int_wake) begin
                    s_nxt.mode = M_SLOW_HF_OFF;
                    s_nxt.idle = 1'b0;
                    s_nxt.res_isr = s_r.master_interrupt_enable;
                end
            end
        endcase
    end

    // state register; reset lands in single normal on the gear clock
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_r <= '0;
            s_r.high_osc_enable <= XEN_RST;
            s_r.wdiv <= WDIV_RST;
            s_r.wcmp <= WCMP_RST;
            s_r.mode <= M_SINGLE_NORMAL;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output decode from registered state
    assign cpu_clk_en = s_r.mode == M_SINGLE_NORMAL || s_r.mode == M_DUAL_NORMAL ||
                        s_r.mode == M_SLOW_HF_ON || s_r.mode == M_SLOW_HF_OFF;
    assign wdt_clk_en = cpu_clk_en;
    assign periph_clk_en = s_r.mode != M_HALT_TB_ONLY;
    assign main_clk_low = s_r.clk_low;
    assign prescaler_run = !s_r.clk_low;
    // crystal pins stay general i/o until dual mode; hence early low enable
    assign xtal_pins_dedicated = !(s_r.mode == M_SINGLE_NORMAL ||
                                   s_r.mode == M_SINGLE_IDLE ||
                                   s_r.mode == M_HALT_TB_ONLY);
    assign high_osc_run = s_r.high_osc_enable;
    assign low_osc_run = s_r.low_osc_enable;
    assign op_mode = s_r.mode;
    assign prdata = s_r.rdata;
    assign warmup_done_interrupt = wu.done;
    assign time_base_interrupt = s_r.tbt_set;
    assign resume_isr = s_r.res_isr;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk iff ce);
    endclocking
    default disable iff (srst);

    property p_reset_mode;
        @(posedge sys_clk) disable iff (1'b0)
        srst |=> op_mode == M_SINGLE_NORMAL && cpu_clk_en && !main_clk_low;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("reset not single normal");

    property p_no_restart;
        (wr_sys2 && s_r.high_osc_enable && s_r.low_osc_enable) |-> !wu.start;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("start while enables held");

    property p_abort_keeps_en;
        wu.abort |-> ##1 (high_osc_run == $past(high_osc_run) &&
                          low_osc_run == $past(low_osc_run)) ##0 !wu.abort;
    endproperty
    a_abort_keeps_en: assert property (p_abort_keeps_en) else $error("abort touched enable");

    sequence s_idle_wake;
        op_mode == M_SINGLE_IDLE && int_wake;
    endsequence
    property p_idle_exit;
        s_idle_wake |=> op_mode == M_SINGLE_NORMAL && resume_isr == $past(s_r.master_interrupt_enable);
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("idle did not end on wake");

    sequence s_halt_fall;
        op_mode == M_HALT_TB_ONLY && tb_fall;
    endsequence
    property p_halt_exit;
        s_halt_fall |=> op_mode == M_SINGLE_NORMAL && periph_clk_en;
    endproperty
    a_halt_exit: assert property (p_halt_exit) else $error("halt did not end on edge");

    property p_tbt_set;
        s_halt_fall ##0 s_r.tb_armed |=> time_base_interrupt ##1 !time_base_interrupt;
    endproperty
    a_tbt_set: assert property (p_tbt_set) else $error("time-base latch not set");

    property p_sw_delay;
        ($rose(s_r.main_clock_select) && s_r.low_osc_enable && !main_clk_low) |=> !main_clk_low ##[1:16] main_clk_low;
    endproperty
    a_sw_delay: assert property (p_sw_delay) else $error("switch-over timing wrong");

    property p_slow_stop;
        (op_mode == M_SLOW_HF_ON || op_mode == M_SLOW_HF_OFF || op_mode == M_LF_SLEEP)
            |-> !prescaler_run && main_clk_low;
    endproperty
    a_slow_stop: assert property (p_slow_stop) else $error("prescaler runs in slow");

    property p_pins;
        (op_mode == M_SINGLE_NORMAL || op_mode == M_SINGLE_IDLE) |-> !xtal_pins_dedicated;
    endproperty
    a_pins: assert property (p_pins) else $error("pins dedicated in single mode");
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the warm-up and operation-mode controller
// assumes a zero-wait apb slave and oscillator ticks given as enables
`timescale 1ns/1ns
module tb_top;
    import owm_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // stimulus and observed signals
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic hf_tick = 1'b0;
    logic lf_tick = 1'b0;
    logic tb_src_clk = 1'b0;
    logic int_wake = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, cpu_clk_en, wdt_clk_en, periph_clk_en, main_clk_low;
    logic prescaler_run, xtal_pins_dedicated, high_osc_run, low_osc_run;
    logic warmup_done_interrupt, time_base_interrupt, resume_isr;
    owm_mode_t op_mode;
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [32:0] rd_q[$];
    logic [2:0] ev_pat[$];
    int ev_cyc[$];

    owm_mode_ctrl #(.SW_DELAY(4)) i_owm_mode_ctrl (.sys_clk(sys_clk), .srst(srst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hf_tick(hf_tick),
        .lf_tick(lf_tick), .tb_src_clk(tb_src_clk), .int_wake(int_wake),
        .cpu_clk_en(cpu_clk_en), .wdt_clk_en(wdt_clk_en), .periph_clk_en(periph_clk_en),
        .main_clk_low(main_clk_low), .prescaler_run(prescaler_run),
        .xtal_pins_dedicated(xtal_pins_dedicated), .high_osc_run(high_osc_run),
        .low_osc_run(low_osc_run), .op_mode(op_mode),
        .warmup_done_interrupt(warmup_done_interrupt),
        .time_base_interrupt(time_base_interrupt), .resume_isr(resume_isr));

    ////////////////////////////////////////////////////////////////////////////////
    // 100 ns clock; low ticks every third cycle so the two sources differ in rate
    always #50 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        hf_tick <= 1'b1;
        lf_tick <= (cyc % 3 == 2);
        if (cyc == 60000) begin
            miscompares = miscompares + 1;
            results();
        end
    end

    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        if (miscompares == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // monitor: every read and every event pulse consumes the oldest note
    always @(posedge sys_clk) begin
        int d;
        if (psel && penable && pready && !pwrite) begin
            if (rd_q.size() == 0) check("read_extra", 33'h1, 33'h0);
            else check("read", {pslverr, prdata}, rd_q.pop_front());
        end
        if (warmup_done_interrupt || time_base_interrupt || resume_isr) begin
            if (ev_pat.size() == 0) begin
                check("event_extra", 33'h1, 33'h0);
            end else begin
                d = cyc - ev_cyc.pop_front();
                check("event", {warmup_done_interrupt, time_base_interrupt, resume_isr},
                    ev_pat.pop_front());
                check("event_time", (d >= -6 && d <= 6), 33'h1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb master: setup, access held until pready, then one idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] dat);
        apb(1'b1, a, dat);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] exp);
        rd_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic mode_is(input logic [2:0] m);
        check("mode", {30'h0, op_mode}, {30'h0, m});
    endtask

    task automatic note(input logic [2:0] p, input int dt);
        ev_pat.push_back(p);
        ev_cyc.push_back(cyc + dt);
    endtask

    // one input pulse of two cycles, driven on rising edges
    task automatic wake();
        @(posedge sys_clk);
        int_wake <= 1'b1;
        repeat (2) @(posedge sys_clk);
        int_wake <= 1'b0;
        settle(3);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int k;
        int c;
        void'($urandom(12177));
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        rd(ADDR_SYS2, 33'(XEN_RST) << B_XEN);
        rd(ADDR_WUC, 33'(WDIV_RST) << B_WDIV);
        rd(ADDR_WCMP, 33'(WCMP_RST));
        rd(ADDR_STAT, 33'h0);
        rd(12'h018, 33'h1_0000_0000);
        check("cpu_en", cpu_clk_en, 33'h1);
        check("pins", xtal_pins_dedicated, 33'h0);
        // idle entry and wake-up, without and with the master enable
        for (k = 0; k < 2; k++) begin
            wr(ADDR_IEN, k);
            wr(ADDR_SYS2, 32'h9);
            settle(2);
            check("cpu_en", cpu_clk_en, 33'h0);
            check("wdt_en", wdt_clk_en, 33'h0);
            check("periph_en", periph_clk_en, 33'h1);
            mode_is(M_SINGLE_IDLE);
            if (k == 1) note(3'b001, 3);
            wake();
            mode_is(M_SINGLE_NORMAL);
        end
        // halted mode, time base disabled then enabled at entry
        wr(ADDR_IEN, 32'h3);
        for (k = 0; k < 2; k++) begin
            wr(ADDR_TBC, k);
            wr(ADDR_SYS2, 32'h11);
            settle(2);
            check("periph_en", periph_clk_en, 33'h0);
            check("cpu_en", cpu_clk_en, 33'h0);
            mode_is(M_HALT_TB_ONLY);
            @(posedge sys_clk);
            tb_src_clk <= 1'b1;
            repeat (3) @(posedge sys_clk);
            if (k == 1) note(3'b011, 2);
            tb_src_clk <= 1'b0;
            settle(3);
            check("periph_en", periph_clk_en, 33'h1);
            mode_is(M_SINGLE_NORMAL);
        end
        // software warm-up over every source and divider code
        for (k = 0; k < 8; k++) begin
            c = 1 + $urandom % 3;
            wr(ADDR_WCMP, c);
            wr(ADDR_WUC, (k % 2) | ((k / 2) << 1));
            wr(ADDR_SYS2, 32'h3);
            note(3'b100, c * 64 * (2 ** (k / 2)) * ((k % 2) ? 3 : 1));
            while (ev_pat.size() != 0) @(posedge sys_clk);
            settle(3);
            mode_is(M_DUAL_NORMAL);
            check("pins", xtal_pins_dedicated, 33'h1);
            check("low_osc", low_osc_run, 33'h1);
            wr(ADDR_SYS2, 32'h3);
            rd(ADDR_STAT, 33'h3);
            wr(ADDR_SYS2, 32'h1);
            settle(2);
            mode_is(M_SINGLE_NORMAL);
            check("pins", xtal_pins_dedicated, 33'h0);
        end
        // abort in mid-count, then restart after clearing the enable
        wr(ADDR_WCMP, 32'hFF);
        wr(ADDR_WUC, 32'h6);
        wr(ADDR_SYS2, 32'h3);
        settle(100);
        rd(ADDR_STAT, 33'h10);
        wr(ADDR_WUC, 32'hE);
        rd(ADDR_WUC, 33'h6);
        rd(ADDR_SYS2, 33'h3);
        rd(ADDR_STAT, 33'h3);
        wr(ADDR_SYS2, 32'h1);
        wr(ADDR_WCMP, 32'h1);
        wr(ADDR_WUC, 32'h0);
        wr(ADDR_SYS2, 32'h3);
        note(3'b100, 64);
        while (ev_pat.size() != 0) @(posedge sys_clk);
        settle(3);
        // dual idle, then slow modes and low-frequency sleep
        wr(ADDR_IEN, 32'h0);
        wr(ADDR_SYS2, 32'hB);
        settle(2);
        mode_is(M_DUAL_IDLE);
        wake();
        mode_is(M_DUAL_NORMAL);
        wr(ADDR_SYS2, 32'h7);
        check("main_low", main_clk_low, 33'h0);
        settle(8);
        check("main_low", main_clk_low, 33'h1);
        check("prescaler", prescaler_run, 33'h0);
        mode_is(M_SLOW_HF_ON);
        wr(ADDR_SYS2, 32'h6);
        settle(2);
        mode_is(M_SLOW_HF_OFF);
        check("high_osc", high_osc_run, 33'h0);
        check("cpu_en", cpu_clk_en, 33'h1);
        wr(ADDR_SYS2, 32'hE);
        settle(2);
        mode_is(M_LF_SLEEP);
        check("prescaler", prescaler_run, 33'h0);
        // clock enable low: a wake pulse seen only while frozen is lost
        @(posedge sys_clk);
        ce <= 1'b0;
        int_wake <= 1'b1;
        repeat (3) @(posedge sys_clk);
        int_wake <= 1'b0;
        ce <= 1'b1;
        settle(2);
        mode_is(M_LF_SLEEP);
        wake();
        mode_is(M_SLOW_HF_OFF);
        // restart the high oscillator, then back to dual normal
        wr(ADDR_SYS2, 32'h7);
        note(3'b100, 64);
        while (ev_pat.size() != 0) @(posedge sys_clk);
        settle(3);
        mode_is(M_SLOW_HF_ON);
        wr(ADDR_SYS2, 32'h3);
        settle(8);
        mode_is(M_DUAL_NORMAL);
        check("main_low", main_clk_low, 33'h0);
        settle(10);
        results();
    end
endmodule
